/* File: wwds_consts.vh */
// Constants for the window watchdog supervisor: timing, limits, period reset value, mode codes.
// Assumes a 200 MHz system clock and a 1 ms tick derived from it.
//
// Function
// - Trigger acts when chip select rises
// - Closed window 60% then open window
// - Seven periods 10 to 1000 ms
// - Good service starts next closed window
// - Closed-window trigger causes reset, restart mode
// - Period change only with valid trigger
// - Failures count; clear on success or devmode
// - Fifteen failures enter fail-safe mode
// - Stop mode off by bits or current
// - Current above threshold restarts long window
// - Stop-mode settings change rejected, flags failure
// - Broken disable sequence clears bit b
// - Normal mode clears bits, long window
// - Bus-wake enable defaults one, normal only
// - Bus wake starts long open window
// - Reset delay end releases reset, long window
// - Development mode: watchdog off, no reset
// - Long window after init; off sleep/restart
// - Fail output held until successful trigger
`ifndef WWDS_CONSTS_VH
`define WWDS_CONSTS_VH
`define WWDS_CLK_MHZ 200
`define WWDS_TICK_US 1000
`define WWDS_TICK_CYC (`WWDS_TICK_US * `WWDS_CLK_MHZ)
`define WWDS_LONG_MS 200
`define WWDS_RESET_DELAY_MS 10
`define WWDS_CLOSED_PCT 60
`define WWDS_OPEN_END_PCT 100
`define WWDS_FAIL_LIMIT 15
`define WWDS_PERIOD_RST 3'h1
`define WWDS_MODE_INIT 3'h0
`define WWDS_MODE_NORMAL 3'h1
`define WWDS_MODE_STOP 3'h2
`define WWDS_MODE_SLEEP 3'h3
`define WWDS_MODE_RESTART 3'h4
`define WWDS_MODE_DEV 3'h5
`define WWDS_MODE_FAILSAFE 3'h6
`endif

/* File: wwds_tick.v */
// Divider giving a one-cycle pulse per tick of the watchdog time base.
// Assumes one system clock; count is a parameter so simulation can shorten it.
`timescale 1ns/100ps
`include "wwds_consts.vh"
module wwds_tick #(
  parameter TICK_CYC = `WWDS_TICK_CYC
) (
  input wire clk_sys,
  input wire rstn,
  output reg tick
);
  reg [31:0] cnt_reg;
  // Free running divider, pulse on wrap
  always @(posedge clk_sys) begin
    if (!rstn) begin
      cnt_reg <= 32'h0000_0000;
      tick <= 1'b0;
    end else if (cnt_reg >= TICK_CYC - 1) begin
      cnt_reg <= 32'h0000_0000;
      tick <= 1'b1;
    end else begin
      cnt_reg <= cnt_reg + 32'h0000_0001;
      tick <= 1'b0;
    end
  end
endmodule

/* File: wwds_top.v */
// Window watchdog supervisor core with mode control and failure escalation.
// Assumes a decoded SPI front end on clk_sys; async pins pass synchronisers.
`timescale 1ns/100ps
`include "wwds_consts.vh"
module wwds_top #(
  parameter TICK_CYC = `WWDS_TICK_CYC,
  parameter LONG_MS = `WWDS_LONG_MS,
  parameter RESET_DELAY_MS = `WWDS_RESET_DELAY_MS
) (
  input wire clk_sys,
  input wire rstn,
  input wire csn_pin,
  input wire wr_ctrl_pend,
  input wire [2:0] wr_period,
  input wire wr_stop_a,
  input wire wr_stop_b,
  input wire wr_bus_en_valid,
  input wire wr_bus_en,
  input wire [2:0] mode_req,
  input wire mode_req_valid,
  input wire load_high_pin,
  input wire bus_wake_pin,
  output reg reset_out_n,
  output reg fail_out_n,
  output reg [2:0] mode,
  output reg [3:0] failure_counter,
  output reg [2:0] period_select_field,
  output reg stop_disable_bit_a,
  output reg stop_disable_bit_b,
  output reg bus_wake_restart_enable,
  output reg spi_fail,
  output reg wd_running,
  output reg wake_irq,
  output reg rxd_low
);
  localparam ST_OFF = 2'h0;
  localparam ST_LONG = 2'h1;
  localparam ST_CLOSED = 2'h2;
  localparam ST_OPEN = 2'h3;
  // Limits cut to counter width on purpose; every documented value fits
  localparam integer CLOSED_PCT_I = `WWDS_CLOSED_PCT;
  localparam integer FAIL_LIMIT_I = `WWDS_FAIL_LIMIT;
  localparam [21:0] PCT_SCALE = 22'h00_0064;
  localparam [10:0] CLOSED_PCT = CLOSED_PCT_I[10:0];
  localparam [10:0] LONG_LIM = LONG_MS[10:0];
  localparam [10:0] DELAY_LIM = RESET_DELAY_MS[10:0];
  localparam [3:0] FAIL_LIM = FAIL_LIMIT_I[3:0];
  wire tick;
  reg [1:0] st_reg;
  reg [10:0] ms_reg;
  reg [1:0] csn_sync_reg;
  reg csn_last_reg;
  reg [1:0] load_sync_reg;
  reg [1:0] wake_sync_reg;
  reg wake_last_reg;
  reg [10:0] rst_cnt_reg;
  reg [2:0] mode_last_reg;
  wire commit;
  wire wake_edge;
  wire load_high;
  wire stop_off;
  reg [10:0] period_ms;
  reg [10:0] closed_ms;
  reg [21:0] closed_wide;
  reg [10:0] new_period_ms;

  wwds_tick #(.TICK_CYC(TICK_CYC)) u_tick (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .tick(tick)
  );

  // Period table, settings one to seven
  function [10:0] wwds_ms;
    input [2:0] sel;
    begin
      case (sel)
        3'h1: wwds_ms = 11'd10;
        3'h2: wwds_ms = 11'd20;
        3'h3: wwds_ms = 11'd50;
        3'h4: wwds_ms = 11'd100;
        3'h5: wwds_ms = 11'd200;
        3'h6: wwds_ms = 11'd500;
        3'h7: wwds_ms = 11'd1000;
        default: wwds_ms = 11'd10;
      endcase
    end
  endfunction

  // Window lengths from the current setting
  always @* begin
    period_ms = wwds_ms(period_select_field);
    closed_wide = ({11'h000, period_ms} * {11'h000, CLOSED_PCT}) / PCT_SCALE;
    closed_ms = closed_wide[10:0];
    new_period_ms = wwds_ms(wr_period);
  end

  // Pin synchronisers; first stage read only by the second
  always @(posedge clk_sys) begin
    if (!rstn) begin
      csn_sync_reg <= 2'b11;
      csn_last_reg <= 1'b1;
      load_sync_reg <= 2'b00;
      wake_sync_reg <= 2'b00;
      wake_last_reg <= 1'b0;
    end else begin
      csn_sync_reg <= {csn_sync_reg[0], csn_pin};
      csn_last_reg <= csn_sync_reg[1];
      load_sync_reg <= {load_sync_reg[0], load_high_pin};
      wake_sync_reg <= {wake_sync_reg[0], bus_wake_pin};
      wake_last_reg <= wake_sync_reg[1];
    end
  end

  // Trigger executes only on chip select rising
  assign commit = wr_ctrl_pend & csn_sync_reg[1] & ~csn_last_reg;
  assign wake_edge = wake_sync_reg[1] & ~wake_last_reg;
  assign load_high = load_sync_reg[1];
  // Stop mode off fully, or only at low current
  assign stop_off = (stop_disable_bit_a & stop_disable_bit_b) | ~load_high;

  // Watchdog window engine and mode handling
  always @(posedge clk_sys) begin
    if (!rstn) begin
      st_reg <= ST_OFF;
      ms_reg <= 11'd0;
      rst_cnt_reg <= 11'd0;
      mode <= `WWDS_MODE_INIT;
      mode_last_reg <= `WWDS_MODE_INIT;
      reset_out_n <= 1'b0;
      fail_out_n <= 1'b1;
      failure_counter <= 4'h0;
      period_select_field <= `WWDS_PERIOD_RST;
      stop_disable_bit_a <= 1'b0;
      stop_disable_bit_b <= 1'b0;
      bus_wake_restart_enable <= 1'b1;
      spi_fail <= 1'b0;
      wd_running <= 1'b0;
      wake_irq <= 1'b0;
      rxd_low <= 1'b0;
    end else begin
      mode_last_reg <= mode;
      wake_irq <= 1'b0;
      wd_running <= (st_reg != ST_OFF);
      if (tick && st_reg != ST_OFF)
        ms_reg <= ms_reg + 11'd1;
      // Host mode requests; restart and fail-safe are held by hardware
      if (mode_req_valid && mode != `WWDS_MODE_RESTART && mode != `WWDS_MODE_FAILSAFE)
        mode <= mode_req;
      if (mode == `WWDS_MODE_INIT && mode_req_valid) begin
        st_reg <= ST_LONG;
        ms_reg <= 11'd0;
        reset_out_n <= 1'b1;
      end
      // Entering normal mode clears stop bits and rearms long window
      if (mode == `WWDS_MODE_NORMAL && mode_last_reg != `WWDS_MODE_NORMAL) begin
        stop_disable_bit_a <= 1'b0;
        stop_disable_bit_b <= 1'b0;
        rxd_low <= 1'b0;
        if (mode_last_reg != `WWDS_MODE_RESTART) begin
          st_reg <= ST_LONG;
          ms_reg <= 11'd0;
        end
      end
      // Modes in which the watchdog stands still
      if (mode == `WWDS_MODE_SLEEP || mode == `WWDS_MODE_DEV ||
          mode == `WWDS_MODE_FAILSAFE || mode == `WWDS_MODE_INIT)
        st_reg <= ST_OFF;
      if (mode == `WWDS_MODE_DEV)
        failure_counter <= 4'h0;
      // Stop mode current and bus-wake handling
      if (mode == `WWDS_MODE_STOP) begin
        if (bus_wake_restart_enable && wake_edge) begin
          st_reg <= ST_LONG;
          ms_reg <= 11'd0;
          wake_irq <= 1'b1;
          rxd_low <= 1'b1;
        end else if (st_reg == ST_OFF && !stop_off) begin
          st_reg <= ST_LONG;
          ms_reg <= 11'd0;
        end else if (st_reg != ST_OFF && stop_off && !rxd_low) begin
          st_reg <= ST_OFF;
        end
      end
      // Stop bits and bus-wake bit written only in normal mode
      if (commit && mode == `WWDS_MODE_NORMAL) begin
        if (wr_bus_en_valid)
          bus_wake_restart_enable <= wr_bus_en;
        // Bit b only after bit a; otherwise sequence broken
        if (wr_stop_b && !stop_disable_bit_a)
          stop_disable_bit_b <= 1'b0;
        else
          stop_disable_bit_b <= wr_stop_b;
        stop_disable_bit_a <= wr_stop_a;
      end
      // Service and closed window hits
      if (commit && mode != `WWDS_MODE_DEV) begin
        if (mode == `WWDS_MODE_STOP && (wr_period != period_select_field ||
            wr_stop_a || wr_stop_b)) begin
          spi_fail <= 1'b1;
          st_reg <= ST_LONG;
          ms_reg <= 11'd0;
        end else if (mode == `WWDS_MODE_STOP && st_reg == ST_OFF) begin
          st_reg <= ST_LONG;
          ms_reg <= 11'd0;
        end else if (st_reg == ST_CLOSED) begin
          st_reg <= ST_OFF;
          mode <= `WWDS_MODE_RESTART;
          reset_out_n <= 1'b0;
          fail_out_n <= 1'b0;
          rst_cnt_reg <= 11'd0;
          failure_counter <= failure_counter + 4'h1;
        end else if (st_reg == ST_OPEN || st_reg == ST_LONG) begin
          st_reg <= ST_CLOSED;
          ms_reg <= 11'd0;
          if (mode == `WWDS_MODE_NORMAL)
            period_select_field <= (wr_period == 3'h0) ? period_select_field : wr_period;
          failure_counter <= 4'h0;
          fail_out_n <= 1'b1;
          rxd_low <= 1'b0;
        end
      end else if (tick) begin
        // Window boundaries on the tick
        if (st_reg == ST_CLOSED && ms_reg + 11'd1 >= closed_ms) begin
          st_reg <= ST_OPEN;
        end else if ((st_reg == ST_OPEN && ms_reg + 11'd1 >= period_ms) ||
                     (st_reg == ST_LONG && ms_reg + 11'd1 >= LONG_LIM)) begin
          st_reg <= ST_OFF;
          mode <= `WWDS_MODE_RESTART;
          reset_out_n <= 1'b0;
          fail_out_n <= 1'b0;
          rst_cnt_reg <= 11'd0;
          failure_counter <= failure_counter + 4'h1;
        end
      end
      // Restart mode: reset delay then normal with long window
      if (mode == `WWDS_MODE_RESTART) begin
        if (failure_counter >= FAIL_LIM) begin
          mode <= `WWDS_MODE_FAILSAFE;
        end else if (tick) begin
          if (rst_cnt_reg + 11'd1 >= DELAY_LIM) begin
            mode <= `WWDS_MODE_NORMAL;
            reset_out_n <= 1'b1;
            st_reg <= ST_LONG;
            ms_reg <= 11'd0;
          end else begin
            rst_cnt_reg <= rst_cnt_reg + 11'd1;
          end
        end
      end
    end
  end
endmodule

/* File: wwds_top_asserts.sv */
// Port-level checks of the watchdog core.
// Assumes binding to wwds_top on its single clock and reset.
`timescale 1ns/100ps
`include "wwds_consts.vh"
module wwds_top_asserts (
  input wire clk_sys,
  input wire rstn,
  input wire reset_out_n,
  input wire fail_out_n,
  input wire [2:0] mode,
  input wire [3:0] failure_counter,
  input wire stop_disable_bit_a,
  input wire stop_disable_bit_b,
  input wire bus_wake_restart_enable,
  input wire wd_running,
  input wire wake_irq,
  input wire rxd_low
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rstn);
  // Steps of a failure and of a bus wake
  sequence s_fail_step;
    failure_counter == $past(failure_counter) + 4'h1;
  endsequence
  sequence s_wake_answer;
    ##[0:1] rxd_low ##1 !wake_irq;
  endsequence
  // Failure escalation, reset output, mode clears and bus wake
  a_fail_pulls_reset: assert property (s_fail_step |-> ##[0:2] !reset_out_n)
    else $error("failure without reset");
  a_fail_sets_fo: assert property (s_fail_step |-> ##[0:2] !fail_out_n)
    else $error("failure without fail output");
  a_fo_release: assert property ($rose(fail_out_n) |-> failure_counter == 4'h0)
    else $error("fail output released early");
  a_restart_holds: assert property (mode == `WWDS_MODE_RESTART |-> !reset_out_n)
    else $error("reset released in restart");
  a_restart_off: assert property (mode == `WWDS_MODE_RESTART && $past(mode) == mode &&
    $past(mode, 2) == mode |-> !wd_running)
    else $error("watchdog runs in restart");
  a_restart_exit: assert property ($rose(reset_out_n) && $past(mode) == `WWDS_MODE_RESTART
    |-> mode == `WWDS_MODE_NORMAL ##2 wd_running)
    else $error("bad restart exit");
  a_failsafe_entry: assert property ($rose(mode == `WWDS_MODE_FAILSAFE) |-> failure_counter == 4'hf)
    else $error("fail-safe at wrong count");
  a_dev_clears: assert property (mode == `WWDS_MODE_DEV |-> ##[0:1] failure_counter == 4'h0)
    else $error("counter kept in development mode");
  a_normal_clears: assert property ($rose(mode == `WWDS_MODE_NORMAL)
    |-> ##[0:1] !stop_disable_bit_a && !stop_disable_bit_b)
    else $error("stop bits kept in normal");
  a_wake_pulse: assert property (wake_irq |-> s_wake_answer)
    else $error("bad wake answer");
  a_bus_en_lock: assert property (mode != `WWDS_MODE_NORMAL |=> $stable(bus_wake_restart_enable))
    else $error("bus wake enable changed");
endmodule
bind wwds_top wwds_top_asserts u_wwds_top_asserts (.clk_sys(clk_sys), .rstn(rstn),
  .reset_out_n(reset_out_n), .fail_out_n(fail_out_n), .mode(mode),
  .failure_counter(failure_counter), .stop_disable_bit_a(stop_disable_bit_a),
  .stop_disable_bit_b(stop_disable_bit_b), .bus_wake_restart_enable(bus_wake_restart_enable),
  .wd_running(wd_running), .wake_irq(wake_irq), .rxd_low(rxd_low));

/* File: wwds_host.sv */
// Host model: an SPI master writing the watchdog control register.
// Assumes the decoded write is qualified until after chip select rises.
`timescale 1ns/100ps
module wwds_host (
  input wire clk_sys,
  output logic csn_pin,
  output logic wr_ctrl_pend,
  output logic [2:0] wr_period,
  output logic wr_stop_a,
  output logic wr_stop_b
);
  initial begin
    csn_pin = 1'b1;
    wr_ctrl_pend = 1'b0;
    {wr_period, wr_stop_a, wr_stop_b} = 5'h00;
  end
  // One write; held past the commit since the pin passes a synchroniser
  task trigger(input logic [2:0] p, input logic a, input logic b);
    @(negedge clk_sys);
    csn_pin = 1'b0;
    wr_period = p;
    {wr_stop_a, wr_stop_b} = {a, b};
    wr_ctrl_pend = 1'b1;
    repeat (4) @(negedge clk_sys);
    csn_pin = 1'b1;
    repeat (4) @(negedge clk_sys);
    wr_ctrl_pend = 1'b0;
    {wr_period, wr_stop_a, wr_stop_b} = ~{p, a, b}; // Released lines show no stale data
  endtask
endmodule

/* File: wwds_top_tb.sv */
// Testbench of the watchdog core with a host model.
// Assumes a 1 ms tick of 10 cycles, a 20 ms long window, 2 ms reset delay.
`timescale 1ns/100ps
`include "wwds_consts.vh"
module wwds_top_tb;
  logic clk_sys, rstn, mode_req_valid, load_high_pin, bus_wake_pin, wr_bus_en_valid, wr_bus_en;
  logic [2:0] mode_req;
  wire csn_pin, wr_ctrl_pend, wr_stop_a, wr_stop_b, reset_out_n, fail_out_n, a_bit, b_bit;
  wire bus_en, spi_fail, wd_running, wake_irq, rxd_low;
  wire [2:0] wr_period, mode, period;
  wire [3:0] fcnt;
  int num_errors = 0;
  int check_count = 0;
  int cyc = 0;
  logic seen_irq = 1'b0;
  wwds_host u_wwds_host (.clk_sys(clk_sys), .csn_pin(csn_pin), .wr_ctrl_pend(wr_ctrl_pend),
    .wr_period(wr_period), .wr_stop_a(wr_stop_a), .wr_stop_b(wr_stop_b));
  wwds_top #(.TICK_CYC(10), .LONG_MS(20), .RESET_DELAY_MS(2)) u_wwds_top (.clk_sys(clk_sys),
    .rstn(rstn), .csn_pin(csn_pin), .wr_ctrl_pend(wr_ctrl_pend), .wr_period(wr_period),
    .wr_stop_a(wr_stop_a), .wr_stop_b(wr_stop_b), .wr_bus_en_valid(wr_bus_en_valid),
    .wr_bus_en(wr_bus_en), .mode_req(mode_req), .mode_req_valid(mode_req_valid),
    .load_high_pin(load_high_pin), .bus_wake_pin(bus_wake_pin), .reset_out_n(reset_out_n),
    .fail_out_n(fail_out_n), .mode(mode), .failure_counter(fcnt), .period_select_field(period),
    .stop_disable_bit_a(a_bit), .stop_disable_bit_b(b_bit), .bus_wake_restart_enable(bus_en),
    .spi_fail(spi_fail), .wd_running(wd_running), .wake_irq(wake_irq), .rxd_low(rxd_low));
  initial begin
    clk_sys = 1'b0;
    forever #2.5 clk_sys = ~clk_sys;
  end
  // Cycle ceiling; the one-cycle interrupt is latched so it cannot slip by
  always @(posedge clk_sys) begin
    cyc++;
    if (wake_irq === 1'b1) seen_irq <= 1'b1;
    if (cyc == 12000) begin
      num_errors++;
      final_report();
    end
  end
  task check(input logic [7:0] seen, input logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task wait_n(input int n);
    repeat (n) @(negedge clk_sys);
  endtask
  task set_mode(input logic [2:0] m);
    mode_req = m;
    mode_req_valid = 1'b1;
    wait_n(1);
    mode_req_valid = 1'b0;
    wait_n(3);
  endtask
  task final_report();
    $display("checks %0d errors %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  initial begin
    {rstn, mode_req_valid, load_high_pin, bus_wake_pin, wr_bus_en_valid, wr_bus_en} = 6'h00;
    mode_req = 3'h0;
    wait_n(3);
    check(reset_out_n, 0);
    check(fail_out_n, 1);
    check(period, 1);
    check(bus_en, 1);
    rstn = 1'b1;
    set_mode(`WWDS_MODE_NORMAL);
    check(wd_running, 1);
    u_wwds_host.trigger(3'h1, 0, 0);
    wait_n(3);
    check(fcnt, 0);
    check(mode, `WWDS_MODE_NORMAL);
    // Back to back: second write lands in the closed window
    u_wwds_host.trigger(3'h1, 0, 0);
    wait_n(3);
    check(mode, `WWDS_MODE_RESTART);
    check(fcnt, 1);
    check(fail_out_n, 0);
    wait_n(40);
    check(reset_out_n, 1);
    check(fail_out_n, 0);
    u_wwds_host.trigger(3'h1, 0, 0);
    wait_n(3);
    check({fail_out_n, fcnt}, 8'h10);
    // New period with a trigger at about 92 percent of the old one
    wait_n(80);
    u_wwds_host.trigger(3'h2, 0, 0);
    wait_n(3);
    check({period, fcnt}, 8'h20);
    // 112 cycles is past the end of the old period but closed under the new one
    wait_n(100);
    u_wwds_host.trigger(3'h0, 0, 0);
    wait_n(3);
    check(fcnt, 1);
    wait_n(300);
    check(fcnt, 2);
    // Disable sequence: b alone is refused, then a, then a with b
    u_wwds_host.trigger(3'h1, 0, 1);
    wait_n(3);
    check(b_bit, 0);
    wait_n(80);
    u_wwds_host.trigger(3'h0, 1, 0);
    wait_n(80);
    u_wwds_host.trigger(3'h0, 1, 1);
    wait_n(3);
    check({a_bit, b_bit}, 3);
    set_mode(`WWDS_MODE_STOP);
    wait_n(250);
    check({wd_running, fcnt}, 8'h00);
    bus_wake_pin = 1'b1;
    wait_n(6);
    bus_wake_pin = 1'b0;
    check({seen_irq, rxd_low, wd_running}, 7);
    u_wwds_host.trigger(3'h3, 0, 0);
    wait_n(3);
    check({spi_fail, period}, 8'h09);
    set_mode(`WWDS_MODE_NORMAL);
    check({a_bit, b_bit, wd_running}, 1);
    // Bus-wake enable rides on a committed write in normal mode
    wr_bus_en_valid = 1'b1;
    u_wwds_host.trigger(3'h0, 0, 0);
    wr_bus_en_valid = 1'b0;
    wait_n(3);
    check(bus_en, 0);
    set_mode(`WWDS_MODE_STOP);
    check(wd_running, 0);
    load_high_pin = 1'b1;
    wait_n(6);
    check(wd_running, 1);
    load_high_pin = 1'b0;
    wait_n(6);
    check(wd_running, 0);
    set_mode(`WWDS_MODE_DEV);
    wait_n(250);
    check({reset_out_n, wd_running, fcnt}, 8'h20);
    // Unserved watchdog: fifteen window expiries in a row
    set_mode(`WWDS_MODE_NORMAL);
    check(wd_running, 1);
    set_mode(`WWDS_MODE_SLEEP);
    check(wd_running, 0);
    set_mode(`WWDS_MODE_NORMAL);
    wait_n(4200);
    check({mode, fcnt}, 8'h6f);
    final_report();
  end
endmodule
